//--- rtl/tc_pkg.sv
// constants and types shared by the touch controller command handler
package tc_pkg;
  // ---------------------------------------------------------------
  // packet framing
  // ---------------------------------------------------------------
  localparam logic [7:0] HDR = 8'h55;
  localparam logic [7:0] RX_MAX = 8'h0c;
  localparam logic [3:0] RX_DAT = 4'h4;
  localparam logic [7:0] MAX_CNT = 8'h08;
  // ---------------------------------------------------------------
  // command ids
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_VER = 8'h10;
  localparam logic [7:0] CMD_TEN = 8'h12;
  localparam logic [7:0] CMD_TDIS = 8'h13;
  localparam logic [7:0] CMD_CAL = 8'h14;
  localparam logic [7:0] CMD_RRD = 8'h20;
  localparam logic [7:0] CMD_RWR = 8'h21;
  localparam logic [7:0] CMD_BASE = 8'h22;
  localparam logic [7:0] CMD_SAVE = 8'h23;
  localparam logic [7:0] CMD_NRD = 8'h28;
  localparam logic [7:0] CAL_4PT = 8'h04;
  // ---------------------------------------------------------------
  // response status and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_UNK = 8'h01;
  localparam logic [7:0] ST_HDR = 8'h03;
  localparam logic [7:0] ST_TMO = 8'h04;
  localparam logic [7:0] ST_CAN = 8'hfc;
  localparam logic [7:0] SZ_ACK = 8'h02;
  localparam logic [7:0] SZ_BASE = 8'h03;
  localparam logic [7:0] SZ_VER = 8'h05;
  localparam logic [7:0] NO_ID = 8'h00;
  // ---------------------------------------------------------------
  // type byte, registers and nonvolatile layout
  // ---------------------------------------------------------------
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [7:0] REG_CNT = 8'h10;
  localparam int REG_OPT = 13;
  localparam int REG_INSET = 14;
  localparam int CCE_BIT = 7;
  localparam int NV_DEPTH = 256;
  localparam logic [7:0] NV_CFG_BASE = 8'h01;
  localparam logic [7:0] NV_CAL_BASE = 8'h15;
  localparam logic [7:0] CAL_BYTES = 8'h11;
  localparam int CAL_FLIP = 16;
  localparam int FL_SWAP = 2;
  localparam int FL_XM = 1;
  localparam int FL_YM = 0;
  localparam logic [9:0] CO_MAX = 10'h3ff;
  localparam int SCALE_SH = 6;
  localparam int INSET_SH = 7;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int TMO_MS = 100;
  localparam int CLK_KHZ = 200000;
  localparam int TMO_CYC = TMO_MS * CLK_KHZ;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [9:0] x;
    logic [9:0] y;
  } tc_pt_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SIZE, RX_BODY} tc_rx_st_t;
endpackage

//--- rtl/tc_cmd_handler.sv
// command interpreter of the resistive touch controller
// Behaviour
// - version query answers size 5: status, id, version hi, lo, type
// - type bits 7:6 give coordinate resolution 00/01/10 = 8/10/12 bit
// - type bits 5:0 carry a fixed six-bit controller kind code
// - touch enable turns reports on and acks with size 2
// - touch disable stops reports; a touch still raises wake
// - calibrate type 4 takes the next four touches as points
// - on completion store points and registers, set calibrated enable
// - any command during calibration cancels it
// - calibrate acks first with size 2 status 0; five packets total
// - extrapolate points by inset, reorder min at UL, max at LR
// - stored coordinate is 10-bit times 64, low byte then high
// - orientation byte: swap bit 2, x mirror 1, y mirror 0
// - register read of 1..8 bytes answers size two plus count
// - address high byte is ignored on register and memory access
// - register write of 1..8 bytes acks with size 2
// - base request answers size 3 with the group start address
// - save command copies registers to nonvolatile memory
// - 256 bytes nonvolatile; low half device, high half user
// - memory read returns the requested stored bytes
// - packets start with 0x55, then size, command id, data
// - status 0 ok, 1 unknown, 3 bad header, 4 timeout, fc cancel
// - no touch reports while a command is being received
`timescale 1ns/100ps
module tc_cmd_handler #(
  parameter int TMO_CYCLES = tc_pkg::TMO_CYC,
  parameter logic [7:0] VER_HI = 8'h01, // arbitrary
  parameter logic [7:0] VER_LO = 8'h00, // arbitrary
  parameter logic [5:0] KIND_CODE = 6'h15, // arbitrary
  parameter logic [7:0] REG_BASE = 8'h20
)(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command bytes from the transport
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // response bytes to the transport
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // touches from acquisition
  input wire logic touch_valid,
  input wire tc_pkg::tc_pt_t touch_pt,
  // coordinate reports and status
  output logic rpt_valid,
  output tc_pkg::tc_pt_t rpt_pt,
  output logic rpt_calibrated,
  output logic wake,
  output logic touch_enabled,
  output logic cal_active,
  output logic receiving
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [9:0] mn(input logic [9:0] a, b);
    mn = (a < b) ? a : b;
  endfunction
  function automatic logic [9:0] mx(input logic [9:0] a, b);
    mx = (a > b) ? a : b;
  endfunction
  function automatic logic [9:0] ad(input logic [9:0] a, b);
    ad = (a > b) ? a - b : b - a;
  endfunction
  function automatic logic [9:0] lo_ext(input logic [9:0] v, d);
    lo_ext = (d > v) ? '0 : v - d;
  endfunction
  function automatic logic [9:0] hi_ext(input logic [9:0] v, d);
    logic [10:0] s;
    s = {1'b0, v} + {1'b0, d};
    hi_ext = s[10] ? tc_pkg::CO_MAX : s[9:0];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tc_pkg::tc_rx_st_t rx_st;
  logic [7:0] rx_size, q_size, q_stat, q_id;
  logic [3:0] rx_cnt, tx_idx, tx_last;
  logic [7:0] rxb [tc_pkg::RX_MAX];
  logic [31:0] tmo_cnt;
  logic exec, hdr_err, tmo, tx_busy;
  logic [7:0] q_dat [tc_pkg::MAX_CNT], rdat [tc_pkg::MAX_CNT];
  logic [7:0] txb [tc_pkg::RX_MAX];
  logic [7:0] rs_size, rs_stat, rs_id;
  logic cal_mode, cal_fin;
  logic [1:0] cal_n;
  tc_pkg::tc_pt_t pts [4];
  logic [7:0] cfg [tc_pkg::REG_CNT], cfg_img [tc_pkg::REG_CNT];
  logic [7:0] nv [tc_pkg::NV_DEPTH];
  logic [15:0] cw [8];
  logic [7:0] cb [tc_pkg::CAL_BYTES];
  logic [7:0] calibration_orientation_byte;
  logic [1:0] coord_resolution;
  logic [5:0] controller_kind_code;
  logic [7:0] version_type_byte;

  assign coord_resolution = tc_pkg::RES_10;
  assign controller_kind_code = KIND_CODE;
  assign version_type_byte = {coord_resolution, controller_kind_code};

  // ---------------------------------------------------------------
  // packet receive
  // ---------------------------------------------------------------
  wire rx_idle = rx_st == tc_pkg::RX_IDLE;
  wire rx_hdr_ok = rx_data == tc_pkg::HDR;
  wire size_ok = rx_data != '0 && rx_data <= tc_pkg::RX_MAX;
  wire rx_last = rx_st == tc_pkg::RX_BODY &&
                 {4'h0, rx_cnt} + 8'h01 == rx_size;
  wire tmo_hit = !rx_idle && tmo_cnt == 32'(TMO_CYCLES - 1);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rx_st <= tc_pkg::RX_IDLE;
      rx_size <= '0;
      rx_cnt <= '0;
      tmo_cnt <= '0;
      exec <= 1'b0;
      hdr_err <= 1'b0;
      tmo <= 1'b0;
    end else begin
      exec <= rx_valid && rx_last;
      hdr_err <= rx_valid && rx_idle && !rx_hdr_ok;
      tmo <= tmo_hit && !rx_valid;
      tmo_cnt <= (rx_valid || rx_idle) ? '0 : tmo_cnt + 32'h1;
      if (rx_valid) begin
        case (rx_st)
          tc_pkg::RX_IDLE: if (rx_hdr_ok) rx_st <= tc_pkg::RX_SIZE;
          tc_pkg::RX_SIZE: begin
            rx_size <= rx_data;
            rx_cnt <= '0;
            rx_st <= size_ok ? tc_pkg::RX_BODY : tc_pkg::RX_IDLE;
          end
          tc_pkg::RX_BODY: begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_last) rx_st <= tc_pkg::RX_IDLE;
          end
          default: rx_st <= tc_pkg::RX_IDLE;
        endcase
      end else if (tmo_hit) begin
        rx_st <= tc_pkg::RX_IDLE;
      end
    end
  end

  // rxb[0] is the command id, [1] address high, [2] address low, [3] count
  for (genvar k = 0; k < tc_pkg::RX_MAX; k++) begin : g_rxb
    always_ff @(posedge mclk) begin
      if (sys_rst) rxb[k] <= '0;
      else if (rx_valid && rx_st == tc_pkg::RX_BODY && rx_cnt == 4'(k))
        rxb[k] <= rx_data;
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire [7:0] cmd = rxb[0];
  wire [7:0] cnt = rxb[3];
  wire cnt_ok = cnt != '0 && cnt <= tc_pkg::MAX_CNT;
  // high address byte rxb[1] never enters the address decode
  wire [7:0] ridx = rxb[2] - REG_BASE;
  wire [7:0] nadr = rxb[2];
  wire cancel = exec && cal_mode;
  wire run = exec && !cal_mode && !tx_busy;
  wire do_wr = run && cmd == tc_pkg::CMD_RWR && cnt_ok;
  wire do_save = run && cmd == tc_pkg::CMD_SAVE;
  wire do_cal = run && cmd == tc_pkg::CMD_CAL &&
                rxb[1] == tc_pkg::CAL_4PT;
  // calibration touches count only while no packet is in flight either way
  wire cal_tch = touch_valid && cal_mode && !tx_busy && rx_idle;
  wire rs_load = (hdr_err || tmo || exec || cal_tch) && !tx_busy;

  always_comb begin
    rs_size = tc_pkg::SZ_ACK;
    rs_stat = tc_pkg::ST_OK;
    rs_id = cmd;
    case (cmd)
      tc_pkg::CMD_VER: rs_size = tc_pkg::SZ_VER;
      tc_pkg::CMD_TEN, tc_pkg::CMD_TDIS, tc_pkg::CMD_SAVE: ;
      tc_pkg::CMD_CAL:
        if (rxb[1] != tc_pkg::CAL_4PT) rs_stat = tc_pkg::ST_UNK;
      tc_pkg::CMD_RRD, tc_pkg::CMD_NRD:
        if (cnt_ok) rs_size = tc_pkg::SZ_ACK + cnt;
        else rs_stat = tc_pkg::ST_UNK;
      tc_pkg::CMD_RWR: if (!cnt_ok) rs_stat = tc_pkg::ST_UNK;
      tc_pkg::CMD_BASE: rs_size = tc_pkg::SZ_BASE;
      default: rs_stat = tc_pkg::ST_UNK;
    endcase
    if (hdr_err) begin
      rs_size = tc_pkg::SZ_ACK;
      rs_stat = tc_pkg::ST_HDR;
      rs_id = tc_pkg::NO_ID;
    end else if (tmo) begin
      rs_size = tc_pkg::SZ_ACK;
      rs_stat = tc_pkg::ST_TMO;
      rs_id = (rx_cnt != '0) ? cmd : tc_pkg::NO_ID;
    end else if (cancel || cal_tch) begin
      rs_size = tc_pkg::SZ_ACK;
      rs_stat = cancel ? tc_pkg::ST_CAN : tc_pkg::ST_OK;
      rs_id = tc_pkg::CMD_CAL;
    end
  end

  // ---------------------------------------------------------------
  // response data and transmit
  // ---------------------------------------------------------------
  for (genvar i = 0; i < tc_pkg::MAX_CNT; i++) begin : g_dat
    wire [7:0] ri = ridx + 8'(i);
    wire [7:0] ni = nadr + 8'(i);
    wire [7:0] vb = (i == 0) ? VER_HI : (i == 1) ? VER_LO :
                    (i == 2) ? version_type_byte : '0;
    wire [7:0] bb = (i == 0) ? REG_BASE : '0;
    wire [7:0] rb = (ri < tc_pkg::REG_CNT) ? cfg[ri[3:0]] : '0;
    assign rdat[i] = (cmd == tc_pkg::CMD_VER) ? vb :
                     (cmd == tc_pkg::CMD_BASE) ? bb :
                     (cmd == tc_pkg::CMD_RRD) ? rb : nv[ni];
    assign txb[tc_pkg::RX_DAT + 4'(i)] = q_dat[i];
    always_ff @(posedge mclk) begin
      if (sys_rst) q_dat[i] <= '0;
      else if (rs_load) q_dat[i] <= rdat[i];
    end
  end
  assign txb[0] = tc_pkg::HDR;
  assign txb[1] = q_size;
  assign txb[2] = q_stat;
  assign txb[3] = q_id;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tx_busy <= 1'b0;
      tx_idx <= '0;
      tx_last <= '0;
      tx_data <= '0;
      q_size <= '0;
      q_stat <= '0;
      q_id <= '0;
    end else if (rs_load) begin
      tx_busy <= 1'b1;
      tx_idx <= '0;
      tx_last <= rs_size[3:0] + 4'h1;
      tx_data <= tc_pkg::HDR;
      q_size <= rs_size;
      q_stat <= rs_stat;
      q_id <= rs_id;
    end else if (tx_busy && tx_ready) begin
      if (tx_idx == tx_last) begin
        tx_busy <= 1'b0;
      end else begin
        tx_idx <= tx_idx + 4'h1;
        tx_data <= txb[tx_idx + 4'h1];
      end
    end
  end
  assign tx_valid = tx_busy;

  // ---------------------------------------------------------------
  // touch enable, reports and calibration sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      touch_enabled <= 1'b1;
      rpt_valid <= 1'b0;
      rpt_pt <= '0;
      wake <= 1'b0;
      cal_mode <= 1'b0;
      cal_n <= '0;
      cal_fin <= 1'b0;
    end else begin
      if (run && cmd == tc_pkg::CMD_TEN) touch_enabled <= 1'b1;
      else if (run && cmd == tc_pkg::CMD_TDIS) touch_enabled <= 1'b0;
      // reports are held off during a command and during calibration
      rpt_valid <= touch_valid && touch_enabled && !cal_mode &&
                   rx_idle;
      rpt_pt <= touch_pt;
      wake <= touch_valid;
      cal_fin <= cal_tch && cal_n == 2'h3;
      if (do_cal) begin
        cal_mode <= 1'b1;
        cal_n <= '0;
      end else if (cancel) begin
        cal_mode <= 1'b0;
      end else if (cal_tch) begin
        cal_n <= cal_n + 2'h1;
        if (cal_n == 2'h3) cal_mode <= 1'b0;
      end
    end
  end
  assign cal_active = cal_mode;
  assign receiving = !rx_idle;

  always_ff @(posedge mclk) begin
    if (cal_tch) pts[cal_n] <= touch_pt;
  end

  // ---------------------------------------------------------------
  // calibration point processing
  // ---------------------------------------------------------------
  wire [9:0] xl = mn(mn(pts[0].x, pts[1].x), mn(pts[2].x, pts[3].x));
  wire [9:0] xh = mx(mx(pts[0].x, pts[1].x), mx(pts[2].x, pts[3].x));
  wire [9:0] yl = mn(mn(pts[0].y, pts[1].y), mn(pts[2].y, pts[3].y));
  wire [9:0] yh = mx(mx(pts[0].y, pts[1].y), mx(pts[2].y, pts[3].y));
  wire [7:0] inset = cfg[tc_pkg::REG_INSET];
  // span times inset over 128 approximates the inset share of full scale
  wire [17:0] px = (xh - xl) * inset;
  wire [17:0] py = (yh - yl) * inset;
  wire [9:0] dx = px[tc_pkg::INSET_SH +: 10];
  wire [9:0] dy = py[tc_pkg::INSET_SH +: 10];
  wire [9:0] ex_l = lo_ext(xl, dx);
  wire [9:0] ex_h = hi_ext(xh, dx);
  wire [9:0] ey_l = lo_ext(yl, dy);
  wire [9:0] ey_h = hi_ext(yh, dy);
  wire [9:0] co [8];
  // order: UL x,y  UR x,y  LR x,y  LL x,y
  assign co = '{ex_l, ey_l, ex_h, ey_l, ex_h, ey_h, ex_l, ey_h};

  always_comb begin
    calibration_orientation_byte = '0;
    calibration_orientation_byte[tc_pkg::FL_SWAP] =
      ad(pts[1].x, pts[0].x) < ad(pts[1].y, pts[0].y);
    calibration_orientation_byte[tc_pkg::FL_XM] = pts[0].x > pts[1].x;
    calibration_orientation_byte[tc_pkg::FL_YM] = pts[0].y > pts[3].y;
  end

  for (genvar c = 0; c < 8; c++) begin : g_cw
    assign cw[c] = 16'({6'h00, co[c]} << tc_pkg::SCALE_SH);
    assign cb[2 * c] = cw[c][7:0];
    assign cb[2 * c + 1] = cw[c][15:8];
  end
  assign cb[tc_pkg::CAL_FLIP] = calibration_orientation_byte;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  for (genvar j = 0; j < tc_pkg::REG_CNT; j++) begin : g_cfg
    wire [7:0] off = 8'(j) - ridx;
    wire hit = do_wr && ridx < tc_pkg::REG_CNT && off < cnt;
    wire cce = cal_fin && j == tc_pkg::REG_OPT;
    assign cfg_img[j] = cfg[j] |
      (cce ? 8'(1 << tc_pkg::CCE_BIT) : '0);
    always_ff @(posedge mclk) begin
      if (sys_rst) cfg[j] <= '0;
      else if (hit) cfg[j] <= rxb[tc_pkg::RX_DAT + {1'b0, off[2:0]}];
      else if (cce) cfg[j] <= cfg_img[j];
    end
  end
  assign rpt_calibrated = cfg[tc_pkg::REG_OPT][tc_pkg::CCE_BIT];

  // ---------------------------------------------------------------
  // nonvolatile store: 0x00-0x7f device data, 0x80-0xff user data
  // ---------------------------------------------------------------
  for (genvar n = 0; n < tc_pkg::NV_DEPTH; n++) begin : g_nv
    wire [7:0] co_i = 8'(n) - tc_pkg::NV_CFG_BASE;
    wire [7:0] ka = 8'(n) - tc_pkg::NV_CAL_BASE;
    wire in_cfg = co_i < tc_pkg::REG_CNT;
    wire in_cal = cal_fin && ka < tc_pkg::CAL_BYTES;
    wire we = ((do_save || cal_fin) && in_cfg) || in_cal;
    wire [7:0] wd = in_cal ? cb[ka[4:0]] : cfg_img[co_i[3:0]];
    always_ff @(posedge mclk) begin
      if (sys_rst) nv[n] <= '0;
      else if (we) nv[n] <= wd;
    end
  end
endmodule

//--- verif/tc_cmd_checker.sv
// assertion checker for the touch controller command handler
`timescale 1ns/100ps
module tc_cmd_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command link
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // touches and reports
  input wire logic touch_valid,
  input wire tc_pkg::tc_pt_t touch_pt,
  input wire logic rpt_valid,
  input wire tc_pkg::tc_pt_t rpt_pt,
  input wire logic rpt_calibrated,
  input wire logic wake,
  input wire logic touch_enabled,
  input wire logic cal_active,
  input wire logic receiving
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------------
  // command and response framing
  // ---------------------------------------------------------------
  sequence s_quiet;
    !receiving && !tx_valid && !cal_active;
  endsequence
  sequence s_rsp_start;
    ##1 tx_valid && tx_data == tc_pkg::HDR;
  endsequence
  a_bad_hdr_rsp: assert property (
    rx_valid && rx_data != tc_pkg::HDR ##0 s_quiet |=> s_rsp_start)
    else $error("bad header byte not answered two edges later");
  a_rx_open: assert property (
    rx_valid && rx_data == tc_pkg::HDR ##0 s_quiet |=> receiving)
    else $error("header byte did not open reception");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte changed before it was taken");
  a_tx_hdr_first: assert property (
    $rose(tx_valid) |-> tx_data == tc_pkg::HDR)
    else $error("response did not open with the header byte");
  // ---------------------------------------------------------------
  // reports, wake and calibration
  // ---------------------------------------------------------------
  a_rpt_follow: assert property (
    touch_valid && touch_enabled && !cal_active && !receiving
    |=> rpt_valid && rpt_pt == $past(touch_pt))
    else $error("enabled touch gave no matching report");
  a_rpt_cause: assert property (
    rpt_valid |-> $past(touch_valid) && $past(touch_enabled))
    else $error("report without an enabled touch");
  a_wake_touch: assert property (touch_valid |=> wake)
    else $error("touch did not raise wake");
  a_rpt_rx_quiet: assert property (
    touch_valid && receiving |=> !rpt_valid)
    else $error("report sent while a command was arriving");
  a_cal_no_rpt: assert property (
    touch_valid && cal_active |=> !rpt_valid)
    else $error("report sent during calibration");
  a_cal_pt_ack: assert property (
    touch_valid && cal_active ##0 !tx_valid && !receiving
    |=> tx_valid && tx_data == tc_pkg::HDR)
    else $error("calibration touch not acknowledged");
  a_cal_done_cce: assert property (
    $fell(cal_active) && $past(touch_valid) |-> ##[1:2] rpt_calibrated)
    else $error("calibrated enable not set after the last point");
endmodule

//--- verif/tc_host_model.sv
// host side model: frames command bytes and takes response bytes
`timescale 1ns/100ps
module tc_host_model (
  // clock
  input wire logic mclk,
  // command bytes towards the handler
  output logic rx_valid,
  output logic [7:0] rx_data,
  // response bytes from the handler
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] rsp [0:15];
  int n_rsp;
  bit slow;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    slow = 1'b0;
  end
  // valid stays up so that bytes of one packet go back to back
  task put(input logic [7:0] b);
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= b;
  endtask
  // a released data line shows the inverse so a stale byte never matches
  task idle();
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask
  task send(input logic [95:0] c, input int nc);
    for (int i = nc - 1; i >= 0; i--)
      put(c[8*i +: 8]);
    idle();
  endtask
  // ready stays low between responses; when slow it toggles
  task get(input int n);
    int t;
    n_rsp = 0;
    t = 0;
    while (n_rsp < n && t < 400) begin
      @(posedge mclk);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
        rsp[n_rsp] = tx_data;
        n_rsp++;
      end
      tx_ready <= (n_rsp < n) && !(slow && tx_ready);
      t++;
    end
  endtask
endmodule

//--- verif/tc_cmd_handler_tb.sv
// self-checking bench for the touch controller command handler
`timescale 1ns/100ps
module tc_cmd_handler_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic touch_valid = 1'b0;
  tc_pkg::tc_pt_t touch_pt = '0;
  logic rx_valid, tx_valid, tx_ready, rpt_valid, rpt_calibrated, wake;
  logic touch_enabled, cal_active, receiving;
  logic [7:0] rx_data, tx_data;
  tc_pkg::tc_pt_t rpt_pt;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2.5 mclk = ~mclk;
  // version and kind values are arbitrary
  tc_cmd_handler #(.TMO_CYCLES(200), .VER_HI(8'h3c), .VER_LO(8'h5a),
    .KIND_CODE(6'h2d)) i_tc_cmd_handler (.mclk(mclk), .sys_rst(sys_rst),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .touch_valid(touch_valid),
    .touch_pt(touch_pt), .rpt_valid(rpt_valid), .rpt_pt(rpt_pt),
    .rpt_calibrated(rpt_calibrated), .wake(wake),
    .touch_enabled(touch_enabled), .cal_active(cal_active),
    .receiving(receiving));
  tc_host_model i_tc_host_model (.mclk(mclk), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task check(input string what, input logic [19:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task expect_rsp(input logic [95:0] e, input int ne);
    logic [7:0] b;
    i_tc_host_model.get(ne);
    check("rsp_len", 20'(i_tc_host_model.n_rsp), 20'(ne));
    for (int i = 0; i < ne; i++) begin
      b = e[8*(ne-1-i) +: 8];
      check("rsp_byte", 20'(i_tc_host_model.rsp[i]), 20'(b));
    end
  endtask
  task run(input logic [95:0] c, input int nc, input logic [95:0] e,
      input int ne);
    i_tc_host_model.send(c, nc);
    expect_rsp(e, ne);
  endtask
  // spare edges first so the previous response has left the link
  task touch(input logic [9:0] x, y, input logic rpt_exp);
    repeat (2) @(posedge mclk);
    touch_valid <= 1'b1;
    touch_pt <= {x, y};
    @(posedge mclk);
    touch_valid <= 1'b0;
    #1;
    check("wake", 20'(wake), 20'h1);
    check("rpt_valid", 20'(rpt_valid), 20'(rpt_exp));
    if (rpt_exp)
      check("rpt_pt", rpt_pt, {x, y});
  endtask
  task cal_pt(input logic [9:0] x, y);
    touch(x, y, 1'b0);
    expect_rsp(96'h55020014, 4);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset();
    @(posedge mclk);
    #1;
    check("touch_enabled", 20'(touch_enabled), 20'h1);
    check("cal_active", 20'(cal_active), 20'h0);
    check("rpt_calibrated", 20'(rpt_calibrated), 20'h0);
    check("receiving", 20'(receiving), 20'h0);
    run(96'h550420002008, 6, 96'h550a0020_0000000000000000, 12);
  endtask
  task t_version();
    i_tc_host_model.slow = 1'b1;
    run(96'h550110, 3, 96'h55050010_3c5a6d, 7);
    i_tc_host_model.slow = 1'b0;
  endtask
  task t_regs();
    logic [7:0] a;
    run(96'h550122, 3, 96'h55030022_20, 5);
    a = i_tc_host_model.rsp[4] + 8'h02;
    run(96'({8'h55, 8'h06, 8'h21, 8'hff, a, 8'h02, 8'ha1, 8'hb2}), 8,
      96'h55020021, 4);
    run(96'({8'h55, 8'h04, 8'h20, 8'h7e, a, 8'h02}), 6,
      96'h55040020_a1b2, 6);
    run(96'h550420002009, 6, 96'h55020120, 4);
    run(96'h550420002000, 6, 96'h55020120, 4);
    run(96'h550420003001, 6, 96'h55030020_00, 5);
    run(96'h550123, 3, 96'h55020023, 4);
    run(96'h550428000302, 6, 96'h55040028_a1b2, 6);
    run(96'h55042800ff02, 6, 96'h55040028_0000, 6);
  endtask
  task t_errors();
    run(96'h550111, 3, 96'h55020111, 4);
    run(96'h55021405, 4, 96'h55020114, 4);
    check("cal_active", 20'(cal_active), 20'h0);
    run(96'h550421002000, 6, 96'h55020121, 4);
    run(96'h77, 1, 96'h55020300, 4);
    run(96'h5501, 2, 96'h55020400, 4);
  endtask
  task t_touch();
    run(96'h550113, 3, 96'h55020013, 4);
    check("touch_enabled", 20'(touch_enabled), 20'h0);
    touch(10'h123, 10'h045, 1'b0);
    run(96'h550112, 3, 96'h55020012, 4);
    touch(10'h3ff, 10'h001, 1'b1);
    i_tc_host_model.put(8'h55);
    i_tc_host_model.idle();
    touch(10'h2aa, 10'h155, 1'b0);
    check("receiving", 20'(receiving), 20'h1);
    run(96'h0112, 2, 96'h55020012, 4);
  endtask
  task t_cal();
    run(96'h55021404, 4, 96'h55020014, 4);
    check("cal_active", 20'(cal_active), 20'h1);
    // points given mirrored in x so the stored order must be fixed up
    cal_pt(10'h384, 10'h0c8);
    cal_pt(10'h064, 10'h0c8);
    cal_pt(10'h064, 10'h320);
    cal_pt(10'h384, 10'h320);
    repeat (10) @(posedge mclk);
    check("cal_active", 20'(cal_active), 20'h0);
    check("rpt_calibrated", 20'(rpt_calibrated), 20'h1);
    run(96'h550428001508, 6, 96'h550a0028_00190032_00e10032, 12);
    run(96'h550428002105, 6, 96'h55070028_001900c8_02, 9);
    run(96'h550428000e01, 6, 96'h55030028_80, 5);
    run(96'h550420002d01, 6, 96'h55030020_80, 5);
    run(96'h55021404, 4, 96'h55020014, 4);
    cal_pt(10'h200, 10'h100);
    run(96'h550110, 3, 96'h5502fc14, 4);
    check("cal_active", 20'(cal_active), 20'h0);
  endtask
  // inset register 8 pushes each edge out by a sixteenth of the span
  task t_inset();
    run(96'h550521002e0108, 7, 96'h55020021, 4);
    run(96'h55021404, 4, 96'h55020014, 4);
    cal_pt(10'h064, 10'h0c8);
    cal_pt(10'h384, 10'h0c8);
    cal_pt(10'h384, 10'h320);
    cal_pt(10'h064, 10'h320);
    repeat (10) @(posedge mclk);
    run(96'h550428001508, 6, 96'h550a0028_800cc028_80edc028, 12);
  endtask
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_version();
    t_regs();
    t_errors();
    t_touch();
    t_cal();
    t_inset();
    complete_run();
  end
  // the whole run needs under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
endmodule
bind tc_cmd_handler tc_cmd_checker i_tc_cmd_checker (.mclk(mclk),
  .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .touch_valid(touch_valid), .touch_pt(touch_pt), .rpt_valid(rpt_valid),
  .rpt_pt(rpt_pt), .rpt_calibrated(rpt_calibrated), .wake(wake),
  .touch_enabled(touch_enabled), .cal_active(cal_active),
  .receiving(receiving));
